// File: hw/stp_tap.sv
`timescale 1ns/10ps
module stp_tap (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rstn,
  input  wire logic                       i_pll_lock,
  input  wire logic                       i_sec_load,
  input  wire logic [stp_pkg::DR_W-1:0]   i_sec_word,
  input  wire logic                       i_otp_programmed,
  input  wire logic                       i_tck,
  input  wire logic                       i_tms,
  input  wire logic                       i_tdi,
  input  wire logic [stp_pkg::NPIN-1:0]   i_pin_in,
  input  wire logic                       i_ctap_tdo,
  input  wire logic [stp_pkg::DR_W-1:0]   i_otp_rdata,
  output logic                            o_boot_start,
  output logic                            o_tdo,
  output logic                            o_tdo_oe,
  output logic                            o_bsr_drive,
  output logic [stp_pkg::NPIN-1:0]        o_bsr_data,
  output logic                            o_ctap_en,
  output logic                            o_ctap_tdi,
  output logic                            o_otp_wr,
  output logic [stp_pkg::DR_W-1:0]        o_otp_wdata
);
  import stp_pkg::*;

  // System clock domain state
  typedef struct packed {
    logic            pll_s1;
    logic            pll_s2;
    logic            boot;
    logic            vld;
    logic            prog;
    logic [DR_W-1:0] sec;
  } stp_sys_type;

  // Test clock domain state
  typedef struct packed {
    stp_state_type   st;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic [DR_W-1:0] dr;
    logic [NPIN-1:0] bsr;
    logic [NPIN-1:0] bsr_upd;
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;
    logic            extest;
    logic            byp;
    logic            ctap_bit;
    logic            ctap_en;
    logic            vld_s1;
    logic            vld_s2;
    logic            sec_ok;
    logic            prog;
    logic [DR_W-1:0] sec;
    logic            otp_wr;
    logic [DR_W-1:0] otp_wdata;
  } stp_tck_type;

  stp_sys_type sys_q, sys_d;
  stp_tck_type tck_q, tck_d;
  logic        tdo_q;
  logic        tdo_oe_q;
  logic        ctap_tdi_q;

  function automatic stp_state_type tap_next(input stp_state_type s, input logic tms);
    unique case (s)
      ST_RESET:  tap_next = tms ? ST_RESET  : ST_IDLE;
      ST_IDLE:   tap_next = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  tap_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: tap_next = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: tap_next = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: tap_next = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: tap_next = tms ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  tap_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: tap_next = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: tap_next = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: tap_next = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_IDLE;
      default:   tap_next = ST_RESET;
    endcase
  endfunction

  // Locked until the security word has arrived, so nothing leaks before it is known
  function automatic stp_dr_sel_type dr_sel(input logic [IR_W-1:0] ir,
                                            input logic sec_ok,
                                            input logic [DR_W-1:0] sec);
    logic tap_lock;
    logic otp_lock;
    tap_lock = !sec_ok || sec[SEC_TAP_DIS];
    otp_lock = !sec_ok || sec[SEC_OTP_DIS];
    unique case (ir)
      INS_EXTEST, INS_SAMPLE:  dr_sel = SEL_BSR;
      INS_DEVICE_IDENTIFICATION_WORD, INS_USERCODE: dr_sel = SEL_WORD;
      INS_CHIPTAP: dr_sel = tap_lock ? SEL_BYP : SEL_CTAP;
      INS_OTP:     dr_sel = otp_lock ? SEL_BYP : SEL_OTP;
      default:     dr_sel = SEL_BYP;
    endcase
  endfunction

  // System domain: security word capture and boot release
  always_comb begin
    sys_d        = sys_q;
    sys_d.pll_s1 = i_pll_lock;
    sys_d.pll_s2 = sys_q.pll_s1;
    // Boot stays held until lock is seen after reset
    if (sys_q.pll_s2) begin
      sys_d.boot = 1'b1;
    end
    // Word is loaded on the edge that raises vld and frozen from then on, so the level alone may cross
    if (i_sec_load && !sys_q.vld) begin
      sys_d.sec  = i_sec_word;
      sys_d.prog = i_otp_programmed;
      sys_d.vld  = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sys_q <= '0;
    end else begin
      sys_q <= sys_d;
    end
  end

  // Test clock domain: controller and scan registers
  always_comb begin
    stp_dr_sel_type sel;
    logic [DR_W-1:0] ucode;
    sel   = dr_sel(tck_q.ir, tck_q.sec_ok, tck_q.sec);
    ucode = '0;
    ucode[UC_REV_W-1:0] = UC_REVISION;
    if (tck_q.prog) begin
      ucode[UC_UID_LSB +: UC_UID_W] = tck_q.sec[SEC_UID_LSB +: UC_UID_W];
    end

    tck_d        = tck_q;
    tck_d.st     = tap_next(tck_q.st, i_tms);
    tck_d.otp_wr = 1'b0;
    tck_d.pin_s1 = i_pin_in;
    tck_d.pin_s2 = tck_q.pin_s1;
    tck_d.vld_s1 = sys_q.vld;
    tck_d.vld_s2 = tck_q.vld_s1;
    if (tck_q.vld_s2 && !tck_q.sec_ok) begin
      tck_d.sec    = sys_q.sec;
      tck_d.prog   = sys_q.prog;
      tck_d.sec_ok = 1'b1;
    end

    unique case (tck_q.st)
      ST_RESET: begin
        tck_d.ir      = IR_RESET;
        tck_d.extest  = 1'b0;
        tck_d.ctap_en = 1'b0;
      end
      ST_CAP_IR: tck_d.ir_sh = IR_CAPTURE;
      ST_SH_IR:  tck_d.ir_sh = {i_tdi, tck_q.ir_sh[IR_W-1:1]};
      ST_UPD_IR: begin
        tck_d.ir      = tck_q.ir_sh;
        tck_d.extest  = (tck_q.ir_sh == INS_EXTEST);
        tck_d.ctap_en = (dr_sel(tck_q.ir_sh, tck_q.sec_ok, tck_q.sec) == SEL_CTAP);
      end
      ST_CAP_DR: begin
        unique case (sel)
          SEL_WORD: tck_d.dr  = (tck_q.ir == INS_DEVICE_IDENTIFICATION_WORD) ? ID_WORD : ucode;
          SEL_BSR:  tck_d.bsr = tck_q.pin_s2;
          SEL_OTP:  tck_d.dr  = i_otp_rdata;
          SEL_CTAP: tck_d.ctap_bit = 1'b0;
          SEL_BYP:  tck_d.byp = 1'b0;
        endcase
      end
      ST_SH_DR: begin
        unique case (sel)
          SEL_WORD, SEL_OTP: tck_d.dr = {i_tdi, tck_q.dr[DR_W-1:1]};
          SEL_BSR:  tck_d.bsr      = {i_tdi, tck_q.bsr[NPIN-1:1]};
          SEL_CTAP: tck_d.ctap_bit = i_ctap_tdo;
          SEL_BYP:  tck_d.byp      = i_tdi;
        endcase
      end
      ST_UPD_DR: begin
        if (sel == SEL_BSR) begin
          tck_d.bsr_upd = tck_q.bsr;
        end
        if (sel == SEL_OTP) begin
          tck_d.otp_wr    = 1'b1;
          tck_d.otp_wdata = tck_q.dr;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge i_tck or negedge i_rstn) begin
    if (!i_rstn) begin
      tck_q    <= '0;
      tck_q.st <= ST_RESET;
      tck_q.ir <= IR_RESET;
    end else begin
      tck_q <= tck_d;
    end
  end

  // Output data changes on the falling edge so the host samples a settled bit
  always_ff @(negedge i_tck or negedge i_rstn) begin
    if (!i_rstn) begin
      tdo_q      <= 1'b0;
      tdo_oe_q   <= 1'b0;
      ctap_tdi_q <= 1'b0;
    end else begin
      ctap_tdi_q <= i_tdi;
      tdo_oe_q   <= (tck_q.st == ST_SH_IR) || (tck_q.st == ST_SH_DR);
      if (tck_q.st == ST_SH_IR) begin
        tdo_q <= tck_q.ir_sh[0];
      end else begin
        unique case (dr_sel(tck_q.ir, tck_q.sec_ok, tck_q.sec))
          SEL_WORD, SEL_OTP: tdo_q <= tck_q.dr[0];
          SEL_BSR:  tdo_q <= tck_q.bsr[0];
          SEL_CTAP: tdo_q <= tck_q.ctap_bit;
          SEL_BYP:  tdo_q <= tck_q.byp;
        endcase
      end
    end
  end

  assign o_boot_start = sys_q.boot;
  assign o_tdo        = tdo_q;
  assign o_tdo_oe     = tdo_oe_q;
  assign o_bsr_drive  = tck_q.extest;
  assign o_bsr_data   = tck_q.bsr_upd;
  assign o_ctap_en    = tck_q.ctap_en;
  assign o_ctap_tdi   = ctap_tdi_q;
  assign o_otp_wr     = tck_q.otp_wr;
  assign o_otp_wdata  = tck_q.otp_wdata;

endmodule // stp_tap

// File: hw/stp_pkg.sv
package stp_pkg;

  // Scan path widths
  localparam int unsigned IR_W  = 4;
  localparam int unsigned DR_W  = 32;
  localparam int unsigned NPIN  = 8;

  // Instruction codes; any other code selects the bypass bit
  localparam logic [3:0] INS_EXTEST   = 4'h0;
  localparam logic [3:0] INS_DEVICE_IDENTIFICATION_WORD   = 4'h1;
  localparam logic [3:0] INS_USERCODE = 4'h2;
  localparam logic [3:0] INS_SAMPLE   = 4'h3;
  localparam logic [3:0] INS_CHIPTAP  = 4'h4;
  localparam logic [3:0] INS_OTP      = 4'h5;
  localparam logic [3:0] INS_BYPASS   = 4'hF;

  // Values after reset and at capture
  localparam logic [3:0] IR_RESET   = INS_DEVICE_IDENTIFICATION_WORD;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // Identification word layout, bit 0 fixed at one
  localparam int unsigned ID_VER_LSB  = 28;
  localparam int unsigned ID_PART_LSB = 12;
  localparam int unsigned ID_MFR_LSB  = 1;
  // Arbitrary neutral identity values
  localparam logic [3:0]  ID_VERSION  = 4'h1;
  localparam logic [15:0] ID_PART     = 16'h5A5A;
  localparam logic [10:0] ID_MFR      = 11'h123;
  localparam logic [31:0] ID_WORD     = {ID_VERSION, ID_PART, ID_MFR, 1'b1};

  // User code word layout
  localparam int unsigned UC_UID_LSB  = 22;
  localparam int unsigned UC_UID_W    = 10;
  localparam int unsigned UC_REV_W    = 16;
  // Arbitrary neutral silicon revision
  localparam logic [15:0] UC_REVISION = 16'h0001;

  // Security register bits
  localparam int unsigned SEC_TAP_DIS = 0;
  localparam int unsigned SEC_OTP_DIS = 13;
  localparam int unsigned SEC_UID_LSB = 22;

  // Reset hold required of the system, for reference by the bench
  localparam int unsigned RST_MIN_NS  = 100;
  localparam int unsigned CLK_NS      = 25;
  localparam int unsigned RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;

  // Sixteen-state controller, one-hot
  typedef enum logic [15:0] {
    ST_RESET    = 16'h0001,
    ST_IDLE     = 16'h0002,
    ST_SEL_DR   = 16'h0004,
    ST_CAP_DR   = 16'h0008,
    ST_SH_DR    = 16'h0010,
    ST_EX1_DR   = 16'h0020,
    ST_PAU_DR   = 16'h0040,
    ST_EX2_DR   = 16'h0080,
    ST_UPD_DR   = 16'h0100,
    ST_SEL_IR   = 16'h0200,
    ST_CAP_IR   = 16'h0400,
    ST_SH_IR    = 16'h0800,
    ST_EX1_IR   = 16'h1000,
    ST_PAU_IR   = 16'h2000,
    ST_EX2_IR   = 16'h4000,
    ST_UPD_IR   = 16'h8000
  } stp_state_type;

  typedef enum logic [4:0] {
    SEL_BYP  = 5'h01,
    SEL_WORD = 5'h02,
    SEL_BSR  = 5'h04,
    SEL_CTAP = 5'h08,
    SEL_OTP  = 5'h10
  } stp_dr_sel_type;

endpackage

// File: dv/stp_host.sv
`timescale 1ns/10ps
module stp_host (
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // Clock moves only here, so it stands still between frames
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    // Move just after the falling edge; the chip-port retimer samples tdi there
    #1 o_tms = tms;
    o_tdi = tdi;
    #23 o_tck = 1'b1;
    tdo = i_tdo_oe ? i_tdo : 1'bx;
    #24 o_tck = 1'b0;
  endtask
  task automatic rst5();
    logic t;
    repeat (5) tick(1'b1, 1'b0, t);
    tick(1'b0, 1'b0, t);
  endtask
  // Starts and ends in idle; LSB first
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic t;
    tick(1'b1, 1'b0, t);
    if (ir) tick(1'b1, 1'b0, t);
    tick(1'b0, 1'b0, t);
    tick(1'b0, 1'b0, t);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], t);
      dout[i] = t;
    end
    tick(1'b1, 1'b0, t);
    tick(1'b0, 1'b0, t);
  endtask
endmodule // stp_host

// File: dv/stp_tap_chk.sv
`timescale 1ns/10ps
module stp_tap_chk (
  input wire logic        i_sys_clk,
  input wire logic        i_rstn,
  input wire logic        i_pll_lock,
  input wire logic        i_sec_load,
  input wire logic [31:0] i_sec_word,
  input wire logic        i_tck,
  input wire logic        i_tms,
  input wire logic        o_boot_start,
  input wire logic        o_bsr_drive,
  input wire logic        o_tdo,
  input wire logic        o_tdo_oe,
  input wire logic        o_ctap_en,
  input wire logic        o_otp_wr
);
  logic       seen_q;
  logic       lk0_q;
  logic       lk13_q;
  logic       tdo_q;
  logic [2:0] ones_q;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      seen_q <= 1'b0;
      lk0_q  <= 1'b0;
      lk13_q <= 1'b0;
    end else if (i_sec_load && !seen_q) begin
      seen_q <= 1'b1;
      lk0_q  <= i_sec_word[0];
      lk13_q <= i_sec_word[13];
    end
  end
  always_ff @(posedge i_tck or negedge i_rstn) begin
    if (!i_rstn) begin
      ones_q <= 3'h0;
      tdo_q  <= 1'b0;
    end else begin
      ones_q <= !i_tms ? 3'h0 : (ones_q == 3'h7 ? ones_q : ones_q + 3'h1);
      tdo_q  <= o_tdo;
    end
  end
  a_boot_wait_lock: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (!i_pll_lock)[*3] ##0 !o_boot_start |=> !o_boot_start) else $error("boot without lock");
  a_boot_rise_time: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    $rose(i_pll_lock) |-> ##[1:4] o_boot_start) else $error("boot late");
  a_boot_level_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    o_boot_start |=> o_boot_start) else $error("boot fell");
  a_tdo_fall_only: assert property (@(negedge i_tck) disable iff (!i_rstn)
    o_tdo == tdo_q) else $error("tdo moved on rising edge");
  a_five_ones_exit: assert property (@(posedge i_tck) disable iff (!i_rstn)
    ones_q >= 3'h5 |=> !o_tdo_oe && !o_ctap_en && !o_bsr_drive)
    else $error("no reset after five ones");
  a_otp_one_pulse: assert property (@(posedge i_tck) disable iff (!i_rstn)
    o_otp_wr |=> !o_otp_wr) else $error("otp write too long");
  a_otp_locked_out: assert property (@(posedge i_tck) disable iff (!i_rstn)
    lk13_q |-> !o_otp_wr) else $error("otp write while locked");
  a_ctap_locked_out: assert property (@(posedge i_tck) disable iff (!i_rstn)
    lk0_q |-> !o_ctap_en) else $error("chip port while locked");
  c_boot: cover property (@(posedge i_sys_clk) $rose(o_boot_start));
  c_otp_wr: cover property (@(posedge i_tck) o_otp_wr);
  c_ctap: cover property (@(posedge i_tck) o_ctap_en);
endmodule // stp_tap_chk

// File: dv/stp_tap_tb_top.sv
`timescale 1ns/10ps
module stp_tap_tb_top;
  import stp_pkg::*;
  logic        clk, rstn, lock, sec_load, otp_prog, tck, tms, tdi;
  logic        tdo, tdo_oe, boot, bsr_drive, ctap_en, ctap_tdi, otp_wr;
  logic [31:0] sec_word, got, otp_wdata;
  logic [7:0]  bsr_data;
  int          otp_wr_n;
  logic [31:0] otp_rd = 32'hC3A5_0F96;
  logic [31:0] pat    = 32'h96C3_5A17;
  logic [7:0]  pins   = 8'h5A;
  int          fails, checks_done, cyc;
  // Chip-level port looped back so its path is exercised
  stp_tap DUT (.i_sys_clk(clk), .i_rstn(rstn), .i_pll_lock(lock), .i_sec_load(sec_load),
    .i_sec_word(sec_word), .i_otp_programmed(otp_prog), .i_tck(tck), .i_tms(tms),
    .i_tdi(tdi), .i_pin_in(pins), .i_ctap_tdo(ctap_tdi), .i_otp_rdata(otp_rd),
    .o_boot_start(boot), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_bsr_drive(bsr_drive),
    .o_bsr_data(bsr_data), .o_ctap_en(ctap_en), .o_ctap_tdi(ctap_tdi), .o_otp_wr(otp_wr),
    .o_otp_wdata(otp_wdata));
  always @(posedge otp_wr) otp_wr_n++;
  stp_host h (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo), .i_tdo_oe(tdo_oe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 8000) begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic do_reset(input logic [31:0] sw, input logic prog);
    logic t;
    #2 rstn = 1'b0;
    lock = 1'b0;
    #1 chk("boot_async", 32'h0, {31'h0, boot});
    h.tick(1'b1, 1'b0, t);
    repeat (20) @(posedge clk);
    #2 rstn = 1'b1;
    @(posedge clk);
    #2 sec_word = sw;
    otp_prog = prog;
    sec_load = 1'b1;
    lock = 1'b1;
    @(posedge clk);
    #2 sec_load = 1'b0;
    @(posedge clk);
    #2 chk("boot_early", 32'h0, {31'h0, boot});
    @(posedge clk);
    #2 chk("boot", 32'h1, {31'h0, boot});
    h.rst5();
  endtask
  task automatic t_codes(input logic [9:0] uid);
    h.scan(1'b0, 32'h0, 32, got);
    chk("device_identification_word", ID_WORD, got);
    h.scan(1'b1, {28'h0, INS_USERCODE}, 4, got);
    chk("ir_capture", {28'h0, IR_CAPTURE}, got);
    h.scan(1'b0, 32'h0, 32, got);
    chk("usercode", {uid, 6'h0, UC_REVISION}, got);
  endtask
  task automatic t_open();
    h.scan(1'b1, {28'h0, INS_CHIPTAP}, 4, got);
    chk("ctap_en", 32'h1, {31'h0, ctap_en});
    // Loopback adds the falling-edge retimer to the one-bit delay
    h.scan(1'b0, pat, 32, got);
    chk("ctap_path", {pat[29:0], 2'b00}, got);
    h.scan(1'b1, {28'h0, INS_OTP}, 4, got);
    h.scan(1'b0, pat, 32, got);
    chk("otp_read", otp_rd, got);
    chk("otp_wdata", pat, otp_wdata);
    chk("otp_wr_pulses", 32'h1, otp_wr_n);
  endtask
  task automatic t_bsr();
    h.scan(1'b1, {28'h0, INS_SAMPLE}, 4, got);
    h.scan(1'b0, 32'h0000_00C3, 8, got);
    chk("bsr_capture", {24'h0, pins}, got);
    chk("bsr_data", 32'h0000_00C3, {24'h0, bsr_data});
    chk("bsr_drive", 32'h0, {31'h0, bsr_drive});
  endtask
  task automatic t_byp(input logic [3:0] c);
    h.scan(1'b1, {28'h0, c}, 4, got);
    h.scan(1'b0, pat, 32, got);
    chk("bypass", {pat[30:0], 1'b0}, got);
    chk("ctap_en", 32'h0, {31'h0, ctap_en});
  endtask
  task automatic t_tms_reset();
    logic t;
    h.scan(1'b1, {28'h0, INS_EXTEST}, 4, got);
    chk("bsr_drive", 32'h1, {31'h0, bsr_drive});
    h.tick(1'b1, 1'b0, t);
    h.tick(1'b0, 1'b0, t);
    h.tick(1'b0, 1'b0, t);
    h.rst5();
    chk("bsr_drive", 32'h0, {31'h0, bsr_drive});
    h.scan(1'b0, 32'h0, 32, got);
    chk("device_identification_word", ID_WORD, got);
  endtask
  initial begin
    // High first, so the first assertion is a real falling edge
    rstn = 1'b1;
    lock = 1'b0;
    otp_wr_n = 0;
    sec_load = 1'b0;
    sec_word = 32'h0;
    otp_prog = 1'b0;
    fails = 0;
    checks_done = 0;
    cyc = 0;
    do_reset(32'hFFC0_0000, 1'b0);
    t_codes(10'h0);
    t_open();
    t_byp(INS_BYPASS);
    t_byp(4'h7);
    t_tms_reset();
    t_bsr();
    @(posedge clk);
    do_reset(32'hABC0_2001, 1'b1);
    t_codes(10'h2AF);
    t_byp(INS_CHIPTAP);
    t_byp(INS_OTP);
    chk("otp_wr_locked", 32'h1, otp_wr_n);
    stop_test();
  end
endmodule // stp_tap_tb_top
bind stp_tap stp_tap_chk u_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
  .i_pll_lock(i_pll_lock), .i_sec_load(i_sec_load), .i_sec_word(i_sec_word),
  .i_tck(i_tck), .i_tms(i_tms), .o_boot_start(o_boot_start), .o_bsr_drive(o_bsr_drive),
  .o_tdo(o_tdo),
  .o_tdo_oe(o_tdo_oe), .o_ctap_en(o_ctap_en), .o_otp_wr(o_otp_wr));
